// *** ces_pkg.sv ***
// Overview of operation
// R1: One 8-bit edge select register per timer.
// R2: Byte and single-bit access, bit touches one.
// R3: Reset clears register to zero.
// R4: Field codes: none, rising, falling, both.
// R5: Bits 3:2 channel one, bits 1:0 channel zero.
// R6: Matching edge gives one-cycle capture strobe.
package ces_pkg;

  localparam int unsigned ADDR_W           = 4;
  localparam logic [3:0]  OFS_EDGE_SELECT  = 4'h0;
  localparam logic [3:0]  OFS_BIT_ACCESS   = 4'h4;
  localparam logic [3:0]  OFS_INPUT_STATUS = 4'h8;
  localparam logic [7:0]  EDGE_SELECT_RST  = 8'h00;
  localparam int unsigned CH0_FIELD_LSB    = 0;
  localparam int unsigned CH1_FIELD_LSB    = 2;
  localparam int unsigned BIT_IDX_LSB      = 0;
  localparam int unsigned BIT_VAL_POS      = 8;
  localparam logic [1:0]  RESP_OKAY        = 2'h0;
  localparam logic [1:0]  RESP_SLVERR      = 2'h2;

  typedef enum logic [1:0] {
    EDGE_NONE    = 2'b00,
    EDGE_RISING  = 2'b01,
    EDGE_FALLING = 2'b10,
    EDGE_BOTH    = 2'b11
  } ces_edge_t;

  // Result of one channel detector toward the capture logic.
  typedef struct packed {
    logic strobe;
    logic level;
  } ces_det_t;

endpackage : ces_pkg

// *** ces_edge_det.sv ***
`timescale 1ns/100ps
`default_nettype none
// One channel: synchroniser, edge detector and the field decoder.
module ces_edge_det (
  input  wire logic         clk_in,
  input  wire logic         rst_in,
  input  wire logic         pin_in,
  input  wire logic [1:0]   sel_in,
  output var  ces_pkg::ces_det_t det_out
);

  logic sync_a;
  logic sync_b;
  logic prev;
  logic rise;
  logic fall;
  logic hit;

  // Two flops tame the asynchronous pin; only sync_b is looked at.
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      sync_a <= 1'b0;
      sync_b <= 1'b0;
      prev   <= 1'b0;
    end else begin
      sync_a <= pin_in;
      sync_b <= sync_a;
      prev   <= sync_b;
    end
  end

  assign rise = sync_b & ~prev;
  assign fall = ~sync_b & prev;

  // Field decode; a none setting can never strobe.
  always_comb begin
    unique case (ces_pkg::ces_edge_t'(sel_in)) // R4
      ces_pkg::EDGE_NONE:    hit = 1'b0;
      ces_pkg::EDGE_RISING:  hit = rise;
      ces_pkg::EDGE_FALLING: hit = fall;
      ces_pkg::EDGE_BOTH:    hit = rise | fall;
    endcase
  end

  // Registered strobe lasts exactly one cycle per edge.
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      det_out <= '0;
    end else begin
      det_out.strobe <= hit; // R6
      det_out.level  <= sync_b;
    end
  end

  chk_none_no_strobe : assert property (
    @(posedge clk_in) disable iff (rst_in)
    (sel_in == 2'b00) |=> !det_out.strobe) // R6
    else $error("Strobe seen with edge detection off.");

  chk_strobe_one_cycle : assert property (
    @(posedge clk_in) disable iff (rst_in)
    det_out.strobe |=> !det_out.strobe) // R6
    else $error("Capture strobe lasted longer than one cycle.");

  chk_rise_decode : assert property (
    @(posedge clk_in) disable iff (rst_in)
    (rise && sel_in == 2'b01) |=> det_out.strobe) // R4
    else $error("Rising edge missed in rising mode.");

  chk_fall_decode : assert property (
    @(posedge clk_in) disable iff (rst_in)
    (fall && sel_in == 2'b01) |=> !det_out.strobe) // R4
    else $error("Falling edge strobed in rising mode.");

endmodule : ces_edge_det
`default_nettype wire

// *** ces_capture_edge_select.sv ***
// The placing of the registers and register access over AXI4-Lite are this design's own decisions.
`timescale 1ns/100ps
`default_nettype none
// Capture edge select register behind an AXI4-Lite slave, two channels.
module ces_capture_edge_select (
  input  wire logic        CLOCK_IN,
  input  wire logic        SYS_RST_IN,
  input  wire logic [3:0]  S_AXI_AWADDR_IN,
  input  wire logic        S_AXI_AWVALID_IN,
  output var  logic        S_AXI_AWREADY_OUT,
  input  wire logic [31:0] S_AXI_WDATA_IN,
  input  wire logic [3:0]  S_AXI_WSTRB_IN,
  input  wire logic        S_AXI_WVALID_IN,
  output var  logic        S_AXI_WREADY_OUT,
  output var  logic [1:0]  S_AXI_BRESP_OUT,
  output var  logic        S_AXI_BVALID_OUT,
  input  wire logic        S_AXI_BREADY_IN,
  input  wire logic [3:0]  S_AXI_ARADDR_IN,
  input  wire logic        S_AXI_ARVALID_IN,
  output var  logic        S_AXI_ARREADY_OUT,
  output var  logic [31:0] S_AXI_RDATA_OUT,
  output var  logic [1:0]  S_AXI_RRESP_OUT,
  output var  logic        S_AXI_RVALID_OUT,
  input  wire logic        S_AXI_RREADY_IN,
  input  wire logic        CAPTURE_INPUT_CH0_IN,
  input  wire logic        CAPTURE_INPUT_CH1_IN,
  output var  logic        CAPTURE_STROBE_CH0_OUT,
  output var  logic        CAPTURE_STROBE_CH1_OUT
);

  logic [7:0]  capture_edge_select;
  logic        aw_held;
  logic [3:0]  aw_addr;
  logic        w_held;
  logic [31:0] w_data;
  logic [3:0]  w_strb;
  logic        do_write;
  logic [7:0]  next_select;
  logic        write_ok;
  logic [1:0]  pins;
  ces_pkg::ces_det_t det [2];
  logic [31:0] next_rdata;
  logic        read_ok;

  // Address and data may arrive in either order; each is held until both.
  assign S_AXI_AWREADY_OUT = !aw_held && !S_AXI_BVALID_OUT;
  assign S_AXI_WREADY_OUT  = !w_held && !S_AXI_BVALID_OUT;
  assign do_write          = aw_held && w_held && !S_AXI_BVALID_OUT;

  always_ff @(posedge CLOCK_IN) begin
    if (SYS_RST_IN) begin
      aw_held <= 1'b0;
      aw_addr <= 4'h0;
    end else if (S_AXI_AWVALID_IN && S_AXI_AWREADY_OUT) begin
      aw_held <= 1'b1;
      aw_addr <= S_AXI_AWADDR_IN;
    end else if (do_write) begin
      aw_held <= 1'b0;
    end
  end

  always_ff @(posedge CLOCK_IN) begin
    if (SYS_RST_IN) begin
      w_held <= 1'b0;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
    end else if (S_AXI_WVALID_IN && S_AXI_WREADY_OUT) begin
      w_held <= 1'b1;
      w_data <= S_AXI_WDATA_IN;
      w_strb <= S_AXI_WSTRB_IN;
    end else if (do_write) begin
      w_held <= 1'b0;
    end
  end

  // Whole-byte write at one offset, single-bit write at another.
  // The bit port carries index in bits 2:0 and value in bit 8, so a bit
  // write never needs a read-modify-write from software.
  always_comb begin
    next_select = capture_edge_select;
    write_ok    = 1'b1;
    if (aw_addr == ces_pkg::OFS_EDGE_SELECT) begin
      if (w_strb[0]) begin
        next_select = w_data[7:0]; // R2
      end
    end else if (aw_addr == ces_pkg::OFS_BIT_ACCESS) begin
      if (w_strb[1]) begin
        next_select[w_data[ces_pkg::BIT_IDX_LSB +: 3]] =
          w_data[ces_pkg::BIT_VAL_POS]; // R2
      end
    end else begin
      write_ok = 1'b0;
    end
  end

  // The one stored register; reset disables both channels.
  always_ff @(posedge CLOCK_IN) begin
    if (SYS_RST_IN) begin
      capture_edge_select <= ces_pkg::EDGE_SELECT_RST; // R3
    end else if (do_write) begin
      capture_edge_select <= next_select; // R1
    end
  end

  // Write response follows once both halves were taken.
  always_ff @(posedge CLOCK_IN) begin
    if (SYS_RST_IN) begin
      S_AXI_BVALID_OUT <= 1'b0;
      S_AXI_BRESP_OUT  <= ces_pkg::RESP_OKAY;
    end else if (do_write) begin
      S_AXI_BVALID_OUT <= 1'b1;
      S_AXI_BRESP_OUT  <= write_ok ? ces_pkg::RESP_OKAY
                                   : ces_pkg::RESP_SLVERR;
    end else if (S_AXI_BREADY_IN) begin
      S_AXI_BVALID_OUT <= 1'b0;
    end
  end

  // Read mux; the status word shows the synchronised pin levels.
  always_comb begin
    next_rdata = 32'h0000_0000;
    read_ok    = 1'b1;
    unique case (S_AXI_ARADDR_IN)
      ces_pkg::OFS_EDGE_SELECT:  next_rdata[7:0] = capture_edge_select;
      ces_pkg::OFS_BIT_ACCESS:   next_rdata[7:0] = capture_edge_select;
      ces_pkg::OFS_INPUT_STATUS: next_rdata[1:0] = {det[1].level,
                                                    det[0].level};
      default:                   read_ok = 1'b0;
    endcase
  end

  assign S_AXI_ARREADY_OUT = !S_AXI_RVALID_OUT;

  always_ff @(posedge CLOCK_IN) begin
    if (SYS_RST_IN) begin
      S_AXI_RVALID_OUT <= 1'b0;
      S_AXI_RDATA_OUT  <= 32'h0000_0000;
      S_AXI_RRESP_OUT  <= ces_pkg::RESP_OKAY;
    end else if (S_AXI_ARVALID_IN && S_AXI_ARREADY_OUT) begin
      S_AXI_RVALID_OUT <= 1'b1;
      S_AXI_RDATA_OUT  <= next_rdata;
      S_AXI_RRESP_OUT  <= read_ok ? ces_pkg::RESP_OKAY
                                  : ces_pkg::RESP_SLVERR;
    end else if (S_AXI_RREADY_IN) begin
      S_AXI_RVALID_OUT <= 1'b0;
    end
  end

  // Each channel reads its own two-bit field, independent of the other.
  assign pins = {CAPTURE_INPUT_CH1_IN, CAPTURE_INPUT_CH0_IN};

  generate
    for (genvar ch = 0; ch < 2; ch++) begin : g_ch
      ces_edge_det u_det (
        .clk_in  (CLOCK_IN),
        .rst_in  (SYS_RST_IN),
        .pin_in  (pins[ch]),
        .sel_in  (capture_edge_select[2*ch +: 2]), // R5
        .det_out (det[ch])
      );
    end
  endgenerate

  assign CAPTURE_STROBE_CH0_OUT = det[0].strobe; // R6
  assign CAPTURE_STROBE_CH1_OUT = det[1].strobe; // R6

  chk_reset_clears : assert property (
    @(posedge CLOCK_IN)
    SYS_RST_IN |=> capture_edge_select == 8'h00) // R3
    else $error("Edge select not cleared by reset.");

  chk_byte_write : assert property (
    @(posedge CLOCK_IN) disable iff (SYS_RST_IN)
    (do_write && aw_addr == 4'h0 && w_strb[0])
      |=> capture_edge_select == $past(w_data[7:0])) // R2
    else $error("Byte write did not land in the register.");

  chk_bit_write_only : assert property (
    @(posedge CLOCK_IN) disable iff (SYS_RST_IN)
    (do_write && aw_addr == 4'h4 && w_strb[1])
      |=> ((capture_edge_select ^ $past(capture_edge_select))
           & ~(8'h01 << $past(w_data[2:0]))) == 8'h00) // R2
    else $error("Bit write disturbed another bit.");

  // The sampled reset in the antecedent keeps the edge that applies a
  // mid-run reset from being mistaken for a spurious change.
  chk_reg_stable : assert property (
    @(posedge CLOCK_IN) disable iff (SYS_RST_IN)
    (!do_write && !SYS_RST_IN) |=> $stable(capture_edge_select)) // R1
    else $error("Edge select changed without a write.");

  chk_bresp_follows : assert property (
    @(posedge CLOCK_IN) disable iff (SYS_RST_IN)
    do_write |=> S_AXI_BVALID_OUT) // R1
    else $error("Write response did not follow the write.");

  // A bit write must land its value at the addressed position.
  chk_bit_write_value : assert property (
    @(posedge CLOCK_IN) disable iff (SYS_RST_IN)
    (do_write && aw_addr == ces_pkg::OFS_BIT_ACCESS && w_strb[1])
      |=> capture_edge_select[$past(w_data[2:0])]
          == $past(w_data[ces_pkg::BIT_VAL_POS])) // R2
    else $error("Bit write did not set the addressed bit.");

  // An unmapped write is refused and the register keeps its value.
  chk_bad_addr_refused : assert property (
    @(posedge CLOCK_IN) disable iff (SYS_RST_IN)
    (do_write && aw_addr != ces_pkg::OFS_EDGE_SELECT
              && aw_addr != ces_pkg::OFS_BIT_ACCESS)
      |=> S_AXI_BRESP_OUT == ces_pkg::RESP_SLVERR
          && $stable(capture_edge_select)) // R1
    else $error("Unmapped write was not refused.");

  // A byte read returns the register with the upper bits zero.
  chk_read_byte : assert property (
    @(posedge CLOCK_IN) disable iff (SYS_RST_IN)
    (S_AXI_ARVALID_IN && S_AXI_ARREADY_OUT
       && S_AXI_ARADDR_IN == ces_pkg::OFS_EDGE_SELECT)
      |=> S_AXI_RDATA_OUT
          == {24'h00_0000, $past(capture_edge_select)}) // R1
    else $error("Byte read returned the wrong value.");

  // A strobe needs its own channel's field enabled one cycle earlier,
  // so a swapped field pair shows whenever one of the two fields is none.
  chk_ch0_own_field : assert property (
    @(posedge CLOCK_IN) disable iff (SYS_RST_IN)
    CAPTURE_STROBE_CH0_OUT
      |-> $past(capture_edge_select[ces_pkg::CH0_FIELD_LSB +: 2])
          != 2'b00) // R5
    else $error("Channel zero strobed with its field off.");

  chk_ch1_own_field : assert property (
    @(posedge CLOCK_IN) disable iff (SYS_RST_IN)
    CAPTURE_STROBE_CH1_OUT
      |-> $past(capture_edge_select[ces_pkg::CH1_FIELD_LSB +: 2])
          != 2'b00) // R5
    else $error("Channel one strobed with its field off.");

endmodule : ces_capture_edge_select
`default_nettype wire

// *** ces_pin_model.sv ***
`timescale 1ns/100ps
`default_nettype none
// Far side: two capture pins driven from outside the timer.
module ces_pin_model (
  input  wire logic       clk_in,
  output var  logic [1:0] pin_out
);
  initial pin_out = 2'b00;

  // Levels change just after an edge and are held eight cycles.
  // That is well past the two-cycle minimum the synchroniser needs.
  task automatic set_pins(input logic [1:0] lvl);
    @(posedge clk_in);
    pin_out <= lvl;
    repeat (8) @(posedge clk_in);
  endtask : set_pins
endmodule : ces_pin_model
`default_nettype wire

// *** tb_top.sv ***
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  logic        clk, rst, awv, wv, brd, arv, rrd;
  logic        awr, wr, bv, arr, rv, s0, s1;
  logic [3:0]  awa, ws, ara;
  logic [31:0] wd, rd, dat;
  logic [1:0]  br, rr, pin, resp;
  int          bad_count, samples_checked, c0, c1, b0, b1;

  ces_capture_edge_select u_ces_capture_edge_select (
    .CLOCK_IN(clk), .SYS_RST_IN(rst), .S_AXI_AWADDR_IN(awa),
    .S_AXI_AWVALID_IN(awv), .S_AXI_AWREADY_OUT(awr),
    .S_AXI_WDATA_IN(wd), .S_AXI_WSTRB_IN(ws), .S_AXI_WVALID_IN(wv),
    .S_AXI_WREADY_OUT(wr), .S_AXI_BRESP_OUT(br), .S_AXI_BVALID_OUT(bv),
    .S_AXI_BREADY_IN(brd), .S_AXI_ARADDR_IN(ara),
    .S_AXI_ARVALID_IN(arv), .S_AXI_ARREADY_OUT(arr),
    .S_AXI_RDATA_OUT(rd), .S_AXI_RRESP_OUT(rr), .S_AXI_RVALID_OUT(rv),
    .S_AXI_RREADY_IN(rrd), .CAPTURE_INPUT_CH0_IN(pin[0]),
    .CAPTURE_INPUT_CH1_IN(pin[1]), .CAPTURE_STROBE_CH0_OUT(s0),
    .CAPTURE_STROBE_CH1_OUT(s1));
  ces_pin_model u_ces_pin_model (.clk_in(clk), .pin_out(pin));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // Counting high cycles, not rising edges, so a stretched strobe shows.
  always @(posedge clk) begin
    c0 <= c0 + int'(s0);
    c1 <= c1 + int'(s1);
  end

  task automatic print_verdict;
    $display("checked %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : print_verdict

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      bad_count++;
      $display("FAIL %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic hang;
    bad_count++;
    $display("FAIL %0t bus handshake timed out", $time);
    print_verdict();
  endtask : hang

  // Handshakes are judged at the falling edge, where ready has settled.
  task automatic wr_reg(input logic [3:0] a, input logic [31:0] d,
                        input logic [3:0] s);
    logic ta, tw, tb;
    int   n;
    @(posedge clk);
    awa <= a;
    wd <= d;
    ws <= s;
    awv <= 1'b1;
    wv <= 1'b1;
    brd <= 1'b1;
    for (n = 0; n < 40; n++) begin
      @(negedge clk);
      ta = awv & awr;
      tw = wv & wr;
      tb = bv;
      resp = br;
      @(posedge clk);
      if (ta) awv <= 1'b0;
      if (tw) wv <= 1'b0;
      if (tb) break;
    end
    brd <= 1'b0;
    if (n == 40) hang();
  endtask : wr_reg

  task automatic rd_reg(input logic [3:0] a);
    logic ta, tr;
    int   n;
    @(posedge clk);
    ara <= a;
    arv <= 1'b1;
    rrd <= 1'b1;
    for (n = 0; n < 40; n++) begin
      @(negedge clk);
      ta = arv & arr;
      tr = rv;
      dat = rd;
      resp = rr;
      @(posedge clk);
      if (ta) arv <= 1'b0;
      if (tr) break;
    end
    rrd <= 1'b0;
    if (n == 40) hang();
  endtask : rd_reg

  initial begin
    {rst, awv, wv, brd, arv, rrd} = 6'h20;
    {awa, ws, ara, wd} = '0;
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    rd_reg(4'h0);
    chk(dat, 32'h0);
    wr_reg(4'h0, 32'hffff_ffa5, 4'hf);
    chk(32'(resp), 32'(ces_pkg::RESP_OKAY));
    rd_reg(4'h0);
    chk(dat, 32'ha5);
    wr_reg(4'h4, 32'h0000_0101, 4'h2);
    rd_reg(4'h4);
    chk(dat, 32'ha7);
    wr_reg(4'h4, 32'h0000_0007, 4'h2);
    rd_reg(4'h0);
    chk(dat, 32'h27);
    // An unmapped place must refuse and leave the register alone.
    wr_reg(4'hc, 32'hff, 4'hf);
    chk(32'(resp), 32'(ces_pkg::RESP_SLVERR));
    rd_reg(4'hc);
    chk(32'(resp), 32'(ces_pkg::RESP_SLVERR));
    chk(dat, 32'h0);
    rd_reg(4'h0);
    chk(dat, 32'h27);
    $display("test registers done");
    // Channel one gets the complement code, so a swapped field shows.
    // Counts are taken as differences, so the counters keep one driver.
    for (int code = 0; code < 4; code++) begin
      wr_reg(4'h0, 32'(code | ((3 - code) << 2)), 4'h1);
      @(negedge clk);
      {b0, b1} = {c0, c1};
      u_ces_pin_model.set_pins(2'b11);
      @(negedge clk);
      chk(32'(c0 - b0), 32'(code & 1));
      chk(32'(c1 - b1), 32'((3 - code) & 1));
      rd_reg(4'h8);
      chk(dat, 32'h3);
      @(negedge clk);
      {b0, b1} = {c0, c1};
      u_ces_pin_model.set_pins(2'b00);
      @(negedge clk);
      chk(32'(c0 - b0), 32'(code >> 1));
      chk(32'(c1 - b1), 32'((3 - code) >> 1));
      rd_reg(4'h8);
      chk(dat, 32'h0);
    end
    $display("test edges done");
    wr_reg(4'h0, 32'hff, 4'h1);
    @(posedge clk);
    rst <= 1'b1;
    @(posedge clk);
    rst <= 1'b0;
    rd_reg(4'h0);
    chk(dat, 32'h0);
    $display("test reset done");
    print_verdict();
  end
endmodule : tb_top
`default_nettype wire
